// [pkg/exposure_range_pkg.sv]
// constants, register indices and reset values for the exposure range stage
// assumes registers are addressed by their word index on the internal register port
package exposure_range_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register indices
    localparam logic [ADDR_W-1:0] IDX_LOOP_CONTROL        = 8'hA0;
    localparam logic [ADDR_W-1:0] IDX_INTEGRATION_FLOOR   = 8'hA8;
    localparam logic [ADDR_W-1:0] IDX_GAIN_FLOOR          = 8'hA9;
    localparam logic [ADDR_W-1:0] IDX_INTEGRATION_CEILING = 8'hAA;
    localparam logic [ADDR_W-1:0] IDX_GAIN_CEILING        = 8'hAB;
    localparam logic [ADDR_W-1:0] IDX_SAMPLE_COUNT        = 8'hB8;
    localparam logic [ADDR_W-1:0] IDX_MEAN_LEVEL          = 8'hBA;
    localparam logic [ADDR_W-1:0] IDX_COMPUTED_INTEG      = 8'hBB;
    localparam logic [ADDR_W-1:0] IDX_COMPUTED_GAINS      = 8'hBC;
    localparam logic [ADDR_W-1:0] IDX_SEQ_CONTROL         = 8'hCC;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_STEP_GRAN   = 8'hD0;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_ARRAY_CLEAR = 8'hD1;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_INTEG       = 8'hD2;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_SECOND      = 8'hD3;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_THIRD       = 8'hD4;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_ANALOG      = 8'hD5;
    localparam logic [ADDR_W-1:0] IDX_APPLIED_FINE_SLOPES = 8'hD6;

    // field positions
    localparam int LOOP_ENABLE_BIT = 0;
    localparam int GAIN_ALIGN_BIT  = 13;
    localparam int STAGE1_LSB      = 0;
    localparam int STAGE2_LSB      = 2;
    localparam int FINE_LSB        = 4;
    localparam int APPLIED_S2_LSB  = 5;
    localparam int DUAL_SLOPE_LSB  = 12;
    localparam int TRIPLE_SLOPE_LSB = 14;
    localparam int MEAN_W          = 10;
    localparam int FINE_W          = 12;

    // reset values
    localparam logic [DATA_W-1:0] RST_INTEGRATION_FLOOR   = 16'h0001;
    localparam logic [DATA_W-1:0] RST_INTEGRATION_CEILING = 16'h0400;
    localparam logic [DATA_W-1:0] RST_GAIN_FLOOR          = 16'h0800;
    localparam logic [DATA_W-1:0] RST_GAIN_CEILING        = 16'hFFF7;
    localparam logic [DATA_W-1:0] RST_COMPUTED_INTEG      = 16'h0001;
    localparam logic [DATA_W-1:0] RST_COMPUTED_GAINS      = 16'h0800;
    localparam logic [DATA_W-1:0] RST_ZERO                = 16'h0000;

    // enforcer tuning: steps below this magnitude touch the fine gain only
    localparam logic [7:0] SMALL_STEP_LIMIT = 8'h10;
    localparam int         INTEG_STEP_SHIFT = 2;

endpackage : exposure_range_pkg

// [rtl/exposure_loop_range_and_status.sv]
// range limiting, update pacing and status reporting of the exposure loop
// assumes frame pulses, statistics and sequencer settings come from logic on clk
// Behaviour
// - fine gain is unsigned 5.7 fixed point, finer than analog stages
// - applied integration time never below the integration floor, unless the floor is set above the ceiling
// - applied integration time never above the integration ceiling, unless the floor is set above the ceiling
// - first analog stage kept between its two-bit floor and ceiling
// - second analog stage kept between its two-bit floor and ceiling
// - fine gain kept between its twelve-bit floor and ceiling
// - loop evaluates and updates parameters only every second frame
// - alignment bit delays gains to land with the delayed integration
// - loop-side computed status updates at evaluating frame end with request
// - sequencer-side status updates when values take effect, lagging loop side
// - read-only status reports the statistics pixel count
// - read-only status reports the ten-bit mean illumination level
// - computed gains: stage one 1:0, stage two 3:2, fine 15:4
// - applied step granularity and array clear reported, global shutter only
// - applied second and third slope times reported, untouched by the loop
// - applied stage one 4:0, stage two 12:5, fine gain twelve bits
// - applied dual and triple slope settings reported, not loop controlled
// - loop runs only while its enable bit is set
// - small corrections move only fine gain; larger ones integration and analog, and fine gain once those sit at their limits
`timescale 1ns/1ps

module exposure_loop_range_and_status
    import exposure_range_pkg::*;
(
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    input  wire logic [exposure_range_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [exposure_range_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output logic      [exposure_range_pkg::DATA_W-1:0]  reg_rdata,
    output logic                                        reg_rvalid,
    input  wire logic                                   frame_start,
    input  wire logic                                   frame_end,
    input  wire logic                                   stat_valid,
    input  wire logic [15:0]                            stat_pixel_count,
    input  wire logic [exposure_range_pkg::MEAN_W-1:0]  stat_mean_level,
    input  wire logic signed [7:0]                      gain_step,
    input  wire logic                                   global_shutter,
    input  wire logic [15:0]                            seq_step_granularity,
    input  wire logic [15:0]                            seq_array_clear,
    input  wire logic [15:0]                            seq_second_slope_time,
    input  wire logic [15:0]                            seq_third_slope_time,
    input  wire logic [1:0]                             seq_dual_slope,
    input  wire logic [1:0]                             seq_triple_slope,
    output logic      [15:0]                            req_integration,
    output logic      [15:0]                            req_gains,
    output logic                                        req_valid
);
    import exposure_range_pkg::*;

    logic [15:0] loop_control_ff;
    logic [15:0] seq_control_ff;
    logic [15:0] integ_floor_ff;
    logic [15:0] integ_ceil_ff;
    logic [15:0] gain_floor_ff;
    logic [15:0] gain_ceil_ff;
    logic [15:0] sample_count_ff;
    logic [9:0]  mean_level_ff;
    logic signed [7:0] step_ff;
    logic        parity_ff;
    logic [15:0] comp_integ_ff;
    logic [15:0] comp_gains_ff;
    logic [15:0] pend_integ_ff;
    logic [15:0] pend_gains_ff;
    logic [15:0] delay_integ_ff;
    logic [15:0] delay_gains_ff;
    logic [15:0] app_integ_ff;
    logic [1:0]  app_s1_ff;
    logic [1:0]  app_s2_ff;
    logic [11:0] app_fine_ff;
    logic [15:0] app_step_gran_ff;
    logic [15:0] app_array_clear_ff;
    logic [15:0] app_second_ff;
    logic [15:0] app_third_ff;
    logic [1:0]  app_dual_ff;
    logic [1:0]  app_triple_ff;
    logic [15:0] rdata_ff;
    logic        rvalid_ff;
    logic [15:0] req_integ_ff;
    logic [15:0] req_gains_ff;
    logic        req_valid_ff;

    logic [15:0] nxt_integ;
    logic [15:0] nxt_gains;
    logic [15:0] nxt_rdata;
    logic        loop_enable;
    logic        gain_align;
    logic        evaluate;

    assign loop_enable = loop_control_ff[LOOP_ENABLE_BIT];
    assign gain_align  = seq_control_ff[GAIN_ALIGN_BIT];
    // every second frame end after enable only, since an integration change needs a frame to act
    assign evaluate    = frame_end & loop_enable & parity_ff;

    // signed wide arithmetic so a step below zero cannot wrap past the floor
    function automatic logic [15:0] clamp(input logic signed [17:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic signed [17:0] slo;
        logic signed [17:0] shi;
        slo = $signed({2'b00, lo});
        shi = $signed({2'b00, hi});
        if (v > shi) begin
            clamp = hi;
        end else if (v < slo) begin
            clamp = lo;
        end else begin
            clamp = v[15:0];
        end
    endfunction : clamp

    // software writes; status indices fall through and are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loop_control_ff <= RST_ZERO;
            seq_control_ff  <= RST_ZERO;
            integ_floor_ff  <= RST_INTEGRATION_FLOOR;
            integ_ceil_ff   <= RST_INTEGRATION_CEILING;
            gain_floor_ff   <= RST_GAIN_FLOOR;
            gain_ceil_ff    <= RST_GAIN_CEILING;
        end else if (reg_wr) begin
            unique case (reg_addr)
                IDX_LOOP_CONTROL:        loop_control_ff <= reg_wdata;
                IDX_SEQ_CONTROL:         seq_control_ff  <= reg_wdata;
                IDX_INTEGRATION_FLOOR:   integ_floor_ff  <= reg_wdata;
                IDX_INTEGRATION_CEILING: integ_ceil_ff   <= reg_wdata;
                IDX_GAIN_FLOOR:          gain_floor_ff   <= reg_wdata;
                IDX_GAIN_CEILING:        gain_ceil_ff    <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // statistics snapshot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_count_ff <= RST_ZERO;
            mean_level_ff   <= RST_ZERO[MEAN_W-1:0];
            step_ff         <= 8'sh00;
        end else if (stat_valid) begin
            sample_count_ff <= stat_pixel_count;
            mean_level_ff   <= stat_mean_level;
            step_ff         <= gain_step;
        end
    end

    // frame parity restarts whenever the loop is off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_ff <= 1'b0;
        end else if (!loop_enable) begin
            parity_ff <= 1'b0;
        end else if (frame_end) begin
            parity_ff <= ~parity_ff;
        end
    end

    // enforcer: fine gain for small steps, then integration and analog stages
    always_comb begin
        logic [1:0]  s1;
        logic [1:0]  s2;
        logic [11:0] fine;
        logic [15:0] integ;
        logic [7:0]  mag;
        logic signed [17:0] fine_sum;
        logic signed [17:0] integ_sum;
        logic signed [17:0] step_w;
        logic [15:0] fine_lo;
        logic [15:0] fine_hi;

        s1        = comp_gains_ff[STAGE1_LSB +: 2];
        s2        = comp_gains_ff[STAGE2_LSB +: 2];
        fine      = comp_gains_ff[FINE_LSB +: FINE_W];
        integ     = comp_integ_ff;
        mag       = step_ff[7] ? 8'(-step_ff) : 8'(step_ff);
        step_w    = 18'(step_ff);
        fine_sum  = $signed({6'h00, fine}) + step_w;
        integ_sum = $signed({2'b00, integ}) + (step_w <<< INTEG_STEP_SHIFT);
        fine_lo   = 16'(gain_floor_ff[FINE_LSB +: FINE_W]);
        fine_hi   = 16'(gain_ceil_ff[FINE_LSB +: FINE_W]);

        if (mag < SMALL_STEP_LIMIT) begin
            fine = 12'(clamp(fine_sum, fine_lo, fine_hi));
        end else if (!step_ff[7]) begin
            if (integ < integ_ceil_ff) begin
                integ = clamp(integ_sum, integ_floor_ff, integ_ceil_ff);
            end else if (s1 < gain_ceil_ff[STAGE1_LSB +: 2]) begin
                s1 = s1 + 2'd1;
            end else if (s2 < gain_ceil_ff[STAGE2_LSB +: 2]) begin
                s2 = s2 + 2'd1;
            end else begin
                fine = 12'(clamp(fine_sum, fine_lo, fine_hi));
            end
        end else begin
            if (s2 > gain_floor_ff[STAGE2_LSB +: 2]) begin
                s2 = s2 - 2'd1;
            end else if (s1 > gain_floor_ff[STAGE1_LSB +: 2]) begin
                s1 = s1 - 2'd1;
            end else if (integ > integ_floor_ff) begin
                integ = clamp(integ_sum, integ_floor_ff, integ_ceil_ff);
            end else begin
                fine = 12'(clamp(fine_sum, fine_lo, fine_hi));
            end
        end
        // final bound pass also catches limits reprogrammed under a running loop
        nxt_integ = clamp($signed({2'b00, integ}), integ_floor_ff, integ_ceil_ff);
        s1 = 2'(clamp($signed({16'h0000, s1}), 16'(gain_floor_ff[STAGE1_LSB +: 2]),
                      16'(gain_ceil_ff[STAGE1_LSB +: 2])));
        s2 = 2'(clamp($signed({16'h0000, s2}), 16'(gain_floor_ff[STAGE2_LSB +: 2]),
                      16'(gain_ceil_ff[STAGE2_LSB +: 2])));
        fine = 12'(clamp($signed({6'h00, fine}), fine_lo, fine_hi));
        nxt_gains = {fine, s2, s1};
    end

    // loop-side status and request to the sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            comp_integ_ff <= RST_COMPUTED_INTEG;
            comp_gains_ff <= RST_COMPUTED_GAINS;
            req_integ_ff  <= RST_COMPUTED_INTEG;
            req_gains_ff  <= RST_COMPUTED_GAINS;
            req_valid_ff  <= 1'b0;
        end else begin
            req_valid_ff <= evaluate;
            if (evaluate) begin
                comp_integ_ff <= nxt_integ;
                comp_gains_ff <= nxt_gains;
                req_integ_ff  <= nxt_integ;
                req_gains_ff  <= nxt_gains;
            end
        end
    end

    // sequencer pipeline: integration lands one frame after it is taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_integ_ff  <= RST_COMPUTED_INTEG;
            pend_gains_ff  <= RST_COMPUTED_GAINS;
            delay_integ_ff <= RST_COMPUTED_INTEG;
            delay_gains_ff <= RST_COMPUTED_GAINS;
            app_integ_ff   <= RST_COMPUTED_INTEG;
            app_s1_ff      <= RST_COMPUTED_GAINS[STAGE1_LSB +: 2];
            app_s2_ff      <= RST_COMPUTED_GAINS[STAGE2_LSB +: 2];
            app_fine_ff    <= RST_COMPUTED_GAINS[FINE_LSB +: FINE_W];
        end else begin
            if (req_valid_ff) begin
                pend_integ_ff <= req_integ_ff;
                pend_gains_ff <= req_gains_ff;
            end
            if (frame_start) begin
                delay_integ_ff <= pend_integ_ff;
                delay_gains_ff <= pend_gains_ff;
                app_integ_ff   <= delay_integ_ff;
                // unaligned gains land a frame ahead of the integration
                if (gain_align) begin
                    app_s1_ff   <= delay_gains_ff[STAGE1_LSB +: 2];
                    app_s2_ff   <= delay_gains_ff[STAGE2_LSB +: 2];
                    app_fine_ff <= delay_gains_ff[FINE_LSB +: FINE_W];
                end else begin
                    app_s1_ff   <= pend_gains_ff[STAGE1_LSB +: 2];
                    app_s2_ff   <= pend_gains_ff[STAGE2_LSB +: 2];
                    app_fine_ff <= pend_gains_ff[FINE_LSB +: FINE_W];
                end
            end
        end
    end

    // settings the loop never drives, captured as they take effect
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            app_step_gran_ff   <= RST_ZERO;
            app_array_clear_ff <= RST_ZERO;
            app_second_ff      <= RST_ZERO;
            app_third_ff       <= RST_ZERO;
            app_dual_ff        <= 2'b00;
            app_triple_ff      <= 2'b00;
        end else if (frame_start) begin
            if (global_shutter) begin
                app_step_gran_ff   <= seq_step_granularity;
                app_array_clear_ff <= seq_array_clear;
            end
            app_second_ff <= seq_second_slope_time;
            app_third_ff  <= seq_third_slope_time;
            app_dual_ff   <= seq_dual_slope;
            app_triple_ff <= seq_triple_slope;
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        unique case (reg_addr)
            IDX_LOOP_CONTROL:        nxt_rdata = loop_control_ff;
            IDX_SEQ_CONTROL:         nxt_rdata = seq_control_ff;
            IDX_INTEGRATION_FLOOR:   nxt_rdata = integ_floor_ff;
            IDX_INTEGRATION_CEILING: nxt_rdata = integ_ceil_ff;
            IDX_GAIN_FLOOR:          nxt_rdata = gain_floor_ff;
            IDX_GAIN_CEILING:        nxt_rdata = gain_ceil_ff;
            IDX_SAMPLE_COUNT:        nxt_rdata = sample_count_ff;
            IDX_MEAN_LEVEL:          nxt_rdata = {6'h00, mean_level_ff};
            IDX_COMPUTED_INTEG:      nxt_rdata = comp_integ_ff;
            IDX_COMPUTED_GAINS:      nxt_rdata = comp_gains_ff;
            IDX_APPLIED_STEP_GRAN:   nxt_rdata = app_step_gran_ff;
            IDX_APPLIED_ARRAY_CLEAR: nxt_rdata = app_array_clear_ff;
            IDX_APPLIED_INTEG:       nxt_rdata = app_integ_ff;
            IDX_APPLIED_SECOND:      nxt_rdata = app_second_ff;
            IDX_APPLIED_THIRD:       nxt_rdata = app_third_ff;
            IDX_APPLIED_ANALOG:      nxt_rdata = {3'b000, 6'h00, app_s2_ff,
                                                  3'b000, app_s1_ff};
            IDX_APPLIED_FINE_SLOPES: nxt_rdata = {app_triple_ff, app_dual_ff,
                                                  app_fine_ff};
            default:                 nxt_rdata = RST_ZERO;
        endcase
    end

    // registered answer one cycle after the strobe; the port never stalls
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff  <= RST_ZERO;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // pins are plain register copies, no logic behind them
    assign reg_rdata       = rdata_ff;
    assign reg_rvalid      = rvalid_ff;
    assign req_integration = req_integ_ff;
    assign req_gains       = req_gains_ff;
    assign req_valid       = req_valid_ff;

endmodule : exposure_loop_range_and_status

// [dv/exposure_range_asserts.sv]
// concurrent checks on the exposure range stage ports
// assumes the limit registers are changed only by writes seen on the register port
`timescale 1ns/1ps

module exposure_range_asserts
    import exposure_range_pkg::*;
(
    input wire logic                                   clk,
    input wire logic                                   reset_n,
    input wire logic [exposure_range_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [exposure_range_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                                   reg_wr,
    input wire logic                                   reg_rd,
    input wire logic [exposure_range_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic                                   reg_rvalid,
    input wire logic                                   frame_end,
    input wire logic [15:0]                            req_integration,
    input wire logic [15:0]                            req_gains,
    input wire logic                                   req_valid
);
    logic [15:0] lo_ff;
    logic [15:0] hi_ff;
    logic [15:0] gc_ff;
    logic [1:0]  ends_ff;

    // shadow of the limits, so clamps can be judged from the ports alone
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lo_ff <= RST_INTEGRATION_FLOOR;
            hi_ff <= RST_INTEGRATION_CEILING;
            gc_ff <= RST_GAIN_CEILING;
        end else if (reg_wr) begin
            if (reg_addr == IDX_INTEGRATION_FLOOR) lo_ff <= reg_wdata;
            if (reg_addr == IDX_INTEGRATION_CEILING) hi_ff <= reg_wdata;
            if (reg_addr == IDX_GAIN_CEILING) gc_ff <= reg_wdata;
        end
    end

    // frame ends since the last request, saturating at two
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ends_ff <= 2'h0;
        end else if (req_valid) begin
            ends_ff <= {1'b0, frame_end};
        end else if (frame_end && ends_ff != 2'h2) begin
            ends_ff <= ends_ff + 2'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered next cycle");
    a_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
    a_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_reads_zero: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == RST_ZERO)
        else $error("unmapped read not zero");
    a_req_after_end: assert property (req_valid |-> $past(frame_end))
        else $error("request not tied to frame end");
    a_req_every_other: assert property (req_valid |-> ends_ff == 2'h2)
        else $error("requests on adjacent frames");
    a_req_held_between: assert property (
        !req_valid |-> $stable(req_integration) && $stable(req_gains))
        else $error("request changed without valid");
    a_integ_not_below: assert property (
        req_valid && lo_ff <= hi_ff |-> req_integration >= lo_ff)
        else $error("integration below floor");
    a_integ_not_above: assert property (req_valid |-> req_integration <= hi_ff)
        else $error("integration above ceiling");
    a_fine_not_above: assert property (req_valid |-> req_gains[15:4] <= gc_ff[15:4])
        else $error("fine gain above ceiling");

    c_request: cover property (req_valid);
    c_status_read: cover property (reg_rd && reg_addr == IDX_COMPUTED_GAINS);
    c_status_write: cover property (reg_wr && reg_addr == IDX_COMPUTED_INTEG);
endmodule : exposure_range_asserts

bind exposure_loop_range_and_status exposure_range_asserts chk_u (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reset_n(reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .frame_end(frame_end), .req_integration(req_integration), .req_gains(req_gains),
    .req_valid(req_valid));

// [dv/exposure_loop_range_and_status_tb_top.sv]
// directed bench for the exposure range stage
// assumes the fixed one-cycle answer latencies of the register port and the loop
`timescale 1ns/1ps

module exposure_loop_range_and_status_tb_top;
    import exposure_range_pkg::*;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              reg_wr = 1'b0, reg_rd = 1'b0, frame_start = 1'b0, frame_end = 1'b0;
    logic              stat_valid = 1'b0, global_shutter = 1'b0, reg_rvalid, req_valid;
    logic [7:0]        reg_addr = 8'h00;
    logic [15:0]       reg_wdata = 16'h0000, stat_pixel_count = 16'h0000, seq_array_clear = 16'h0000;
    logic [15:0]       seq_step_granularity = 16'h0000, seq_second_slope_time = 16'h0000;
    logic [15:0]       seq_third_slope_time = 16'h0000, reg_rdata, req_integration, req_gains;
    logic [9:0]        stat_mean_level = 10'h000;
    logic signed [7:0] gain_step = 8'sh00;
    logic [1:0]        seq_dual_slope = 2'h0, seq_triple_slope = 2'h0;
    int                num_errors = 0;
    int                num_checks = 0;

    always #25 clk = ~clk;

    exposure_loop_range_and_status dut_u (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .frame_start(frame_start), .frame_end(frame_end), .stat_valid(stat_valid),
        .stat_pixel_count(stat_pixel_count), .stat_mean_level(stat_mean_level),
        .gain_step(gain_step), .global_shutter(global_shutter),
        .seq_step_granularity(seq_step_granularity), .seq_array_clear(seq_array_clear),
        .seq_second_slope_time(seq_second_slope_time),
        .seq_third_slope_time(seq_third_slope_time), .seq_dual_slope(seq_dual_slope),
        .seq_triple_slope(seq_triple_slope), .req_integration(req_integration),
        .req_gains(req_gains), .req_valid(req_valid));

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // answer is fixed at one cycle, so no wait loop is needed
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rvalid", {15'h0000, reg_rvalid}, 16'h0001);
        chk($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rd

    // 0 frame start, 1 frame end, 2 statistics strobe
    task pulse(input int which);
        @(posedge clk);
        if (which == 0) frame_start <= 1'b1;
        else if (which == 1) frame_end <= 1'b1;
        else stat_valid <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        frame_end <= 1'b0;
        stat_valid <= 1'b0;
        #1;
    endtask : pulse

    task do_eval(input logic signed [7:0] step, input logic [15:0] e_int, input logic [15:0] e_g);
        @(posedge clk);
        gain_step <= step;
        pulse(2);
        pulse(1);
        chk("req_valid odd", {15'h0000, req_valid}, 16'h0000);
        pulse(1);
        chk("req_valid even", {15'h0000, req_valid}, 16'h0001);
        chk("req_integration", req_integration, e_int);
        chk("req_gains", req_gains, e_g);
    endtask : do_eval

    task t_reset();
        chk("req_integration rst", req_integration, RST_COMPUTED_INTEG);
        chk("req_gains rst", req_gains, RST_COMPUTED_GAINS);
        rd(IDX_INTEGRATION_FLOOR, RST_INTEGRATION_FLOOR);
        rd(IDX_INTEGRATION_CEILING, RST_INTEGRATION_CEILING);
        rd(IDX_GAIN_FLOOR, RST_GAIN_FLOOR);
        rd(IDX_GAIN_CEILING, RST_GAIN_CEILING);
        rd(8'h00, RST_ZERO);
        wr(IDX_COMPUTED_INTEG, 16'h1234);
        rd(IDX_COMPUTED_INTEG, RST_COMPUTED_INTEG);
        wr(IDX_APPLIED_INTEG, 16'h5678);
        rd(IDX_APPLIED_INTEG, 16'h0001);
        pulse(1);
        pulse(1);
        chk("req_valid disabled", {15'h0000, req_valid}, 16'h0000);
    endtask : t_reset

    // small step touches fine gain only, and the fine ceiling bites
    task t_small();
        wr(IDX_GAIN_CEILING, 16'h0827);
        wr(IDX_LOOP_CONTROL, 16'h0001);
        stat_pixel_count <= 16'h1234;
        stat_mean_level <= 10'h2AB;
        do_eval(8'sh05, 16'h0001, 16'h0820);
        rd(IDX_SAMPLE_COUNT, 16'h1234);
        rd(IDX_MEAN_LEVEL, 16'h02AB);
        rd(IDX_COMPUTED_INTEG, 16'h0001);
        rd(IDX_COMPUTED_GAINS, 16'h0820);
    endtask : t_small

    task t_large();
        wr(IDX_INTEGRATION_CEILING, 16'h0040);
        rd(IDX_INTEGRATION_CEILING, 16'h0040);
        do_eval(8'sh20, 16'h0040, 16'h0820);
    endtask : t_large

    task t_seq();
        @(posedge clk);
        global_shutter <= 1'b1;
        seq_step_granularity <= 16'h0111;
        seq_array_clear <= 16'h0222;
        seq_second_slope_time <= 16'h0333;
        seq_third_slope_time <= 16'h0444;
        seq_dual_slope <= 2'h2;
        seq_triple_slope <= 2'h1;
        pulse(0);
        rd(IDX_APPLIED_INTEG, 16'h0001);
        rd(IDX_APPLIED_FINE_SLOPES, 16'h6082);
        rd(IDX_APPLIED_STEP_GRAN, 16'h0111);
        rd(IDX_APPLIED_ARRAY_CLEAR, 16'h0222);
        rd(IDX_APPLIED_SECOND, 16'h0333);
        rd(IDX_APPLIED_THIRD, 16'h0444);
        pulse(0);
        rd(IDX_APPLIED_INTEG, 16'h0040);
    endtask : t_seq

    // integration sits at its ceiling, so the first analog stage moves
    task t_align();
        wr(IDX_SEQ_CONTROL, 16'h2000);
        global_shutter <= 1'b0;
        seq_step_granularity <= 16'h0999;
        do_eval(8'sh20, 16'h0040, 16'h0821);
        pulse(0);
        rd(IDX_APPLIED_ANALOG, 16'h0000);
        rd(IDX_APPLIED_STEP_GRAN, 16'h0111);
        pulse(0);
        rd(IDX_APPLIED_ANALOG, 16'h0001);
        do_eval(8'shE0, 16'h0040, 16'h0820);
        do_eval(8'shE0, 16'h0001, 16'h0820);
    endtask : t_align

    initial begin
        #2000000;
        num_errors += 1;
        conclude();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_small();
        t_large();
        t_seq();
        t_align();
        conclude();
    end
endmodule : exposure_loop_range_and_status_tb_top
